//--- hw/bpoc_req_hold.sv
// Bus request hold logic for one internal master
`timescale 1ns/1ps
`default_nettype none
module bpoc_req_hold (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic want_i,
    input wire logic hold_long_i,
    input wire logic long_lock_i,
    input wire logic lock_i,
    input wire logic frame_n_i,
    input wire logic pending_i,
    input wire logic target_term_i,
    output logic req_n_o
);
    bpoc_pkg::bpoc_req_state_t state_q, state_d;
    logic long_q, long_d;

    always_comb
    begin
        state_d = state_q;
        long_d = long_q;
        case (state_q)
            bpoc_pkg::BPOC_REQ_IDLE:
                if (want_i)
                begin
                    state_d = bpoc_pkg::BPOC_REQ_WAIT;
                    // Mode latched at request start only
                    long_d = hold_long_i || (long_lock_i && lock_i);
                end
            bpoc_pkg::BPOC_REQ_WAIT:
                if (!frame_n_i)
                begin
                    state_d = long_q ? bpoc_pkg::BPOC_REQ_HOLD
                                     : bpoc_pkg::BPOC_REQ_IDLE;
                end
            bpoc_pkg::BPOC_REQ_HOLD:
                if (!pending_i || target_term_i)
                begin
                    state_d = bpoc_pkg::BPOC_REQ_IDLE;
                end
            default:
                state_d = bpoc_pkg::BPOC_REQ_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= bpoc_pkg::BPOC_REQ_IDLE;
            long_q <= 1'b0;
        end
        else if (ce_i)
        begin
            state_q <= state_d;
            long_q <= long_d;
        end
    end

    assign req_n_o = (state_q == bpoc_pkg::BPOC_REQ_IDLE);
endmodule
`default_nettype wire

//--- hw/bpoc_retry_match.sv
// Retry command matcher for one bridge port
`timescale 1ns/1ps
`default_nettype none
module bpoc_retry_match (
    input wire logic [3:0] retry_cmd_i,
    input wire logic [3:0] queued_cmd_i,
    input wire logic rd_alias_i,
    input wire logic wr_alias_i,
    input wire logic lm_alias_i,
    output logic match_o
);
    function automatic logic is_rl_rm(input logic [3:0] c);
        is_rl_rm = (c == bpoc_pkg::MEMORY_READ_LINE_CMD) ||
                   (c == bpoc_pkg::MEMORY_READ_MULTIPLE_CMD);
    endfunction

    always_comb
    begin
        match_o = (retry_cmd_i == queued_cmd_i);
        // Line or multiple retry hits a plain read
        if (rd_alias_i && is_rl_rm(retry_cmd_i) &&
            queued_cmd_i == bpoc_pkg::PLAIN_MEMORY_READ_CMD)
        begin
            match_o = 1'b1;
        end
        // Line and multiple alias each other
        if (lm_alias_i && is_rl_rm(retry_cmd_i) && is_rl_rm(queued_cmd_i))
        begin
            match_o = 1'b1;
        end
        // Write-invalidate retry hits a plain write
        if (wr_alias_i &&
            retry_cmd_i == bpoc_pkg::WRITE_AND_INVALIDATE_CMD &&
            queued_cmd_i == bpoc_pkg::PLAIN_MEMORY_WRITE_CMD)
        begin
            match_o = 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- hw/bpoc_top.sv
// Port option register and its steering of retry match and requests
// How it works
// RL1 - Bit 0 and bits 15:12 are read-only and read zero.
// RL2 - Bit 1 lets primary line/multiple read retries match queued plain read.
// RL3 - Bit 2 lets primary write-invalidate retries match queued plain write.
// RL4 - Bit 3 lets secondary line/multiple read retries match plain read.
// RL5 - Bit 4 lets secondary write-invalidate retries match plain write.
// RL6 - Bit 5 makes primary read line and read multiple alias each other.
// RL7 - Bit 6 makes secondary read line and read multiple alias each other.
// RL8 - Bit 7 clear converts primary write-invalidate to write; set disconnects.
// RL9 - Bit 8 does the same for secondary-side write-invalidate.
// RL10 - Bit 9 enables long requests for locked cycles.
// RL11 - Bit 10 makes secondary master hold request until FIFO empty or stop.
// RL12 - Bit 11 does the same for the primary master.
// RL13 - New settings affect only comparisons and requests after the write.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module bpoc_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Primary side retry compare
    input wire logic [3:0] p_retry_cmd_i,
    input wire logic [3:0] p_queued_cmd_i,
    output logic p_match_o,
    // Secondary side retry compare
    input wire logic [3:0] s_retry_cmd_i,
    input wire logic [3:0] s_queued_cmd_i,
    output logic s_match_o,
    // Write-invalidate forwarding
    input wire logic [3:0] p_accept_cmd_i,
    input wire logic [3:0] s_accept_cmd_i,
    output logic [3:0] s_fwd_cmd_o,
    output logic [3:0] p_fwd_cmd_o,
    output logic p_wi_disc_o,
    output logic s_wi_disc_o,
    // Primary internal master request
    input wire logic p_want_i,
    input wire logic p_lock_i,
    input wire logic p_frame_n_i,
    input wire logic p_pending_i,
    input wire logic p_target_term_i,
    output logic p_req_n_o,
    // Secondary internal master request
    input wire logic s_want_i,
    input wire logic s_lock_i,
    input wire logic s_frame_n_i,
    input wire logic s_pending_i,
    input wire logic s_target_term_i,
    output logic s_req_n_o
);
    logic [15:0] opt_q, opt_d;
    logic ack_q, ack_d;
    logic err_q, err_d;
    logic [31:0] dat_q, dat_d;
    logic p_fr1_q, p_fr2_q, s_fr1_q, s_fr2_q;
    logic p_frame_n_s, s_frame_n_s;
    logic hit;

    // PCI frame pins cross in through two flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            p_fr1_q <= 1'b1;
            p_fr2_q <= 1'b1;
            s_fr1_q <= 1'b1;
            s_fr2_q <= 1'b1;
        end
        else if (ce_i)
        begin
            p_fr1_q <= p_frame_n_i;
            p_fr2_q <= p_fr1_q;
            s_fr1_q <= s_frame_n_i;
            s_fr2_q <= s_fr1_q;
        end
    end
    assign p_frame_n_s = p_fr2_q;
    assign s_frame_n_s = s_fr2_q;

    assign hit = (wb_adr_i == bpoc_pkg::OPT_ADDR);

    // Register file and bus answer
    always_comb
    begin
        opt_d = opt_q;
        ack_d = 1'b0;
        err_d = 1'b0;
        dat_d = dat_q;
        if (wb_cyc_i && wb_stb_i && !ack_q && !err_q)
        begin
            if (hit)
            begin
                ack_d = 1'b1;
                if (wb_we_i)
                begin
                    // RL1 reserved bits stay zero
                    if (wb_sel_i[0])
                    begin
                        opt_d[7:0] = wb_dat_i[7:0] & bpoc_pkg::OPT_WMASK[7:0];
                    end
                    if (wb_sel_i[1])
                    begin
                        opt_d[15:8] = wb_dat_i[15:8] &
                                      bpoc_pkg::OPT_WMASK[15:8];
                    end
                end
                else
                begin
                    dat_d = {16'h0000, opt_q};
                end
            end
            else
            begin
                // Unmapped address answers with an error
                err_d = 1'b1;
                dat_d = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            opt_q <= bpoc_pkg::OPT_RESET;
            ack_q <= 1'b0;
            err_q <= 1'b0;
            dat_q <= 32'h00000000;
        end
        else if (ce_i)
        begin
            opt_q <= opt_d;
            ack_q <= ack_d;
            err_q <= err_d;
            dat_q <= dat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
    assign wb_dat_o = dat_q;

    // RL13 registered options seen from the same cycle as the ack
    // RL2 RL3 RL6 primary retry alias
    bpoc_retry_match u_p_match (
        .retry_cmd_i(p_retry_cmd_i),
        .queued_cmd_i(p_queued_cmd_i),
        .rd_alias_i(opt_q[bpoc_pkg::P_RD_ALIAS_POS]),
        .wr_alias_i(opt_q[bpoc_pkg::P_WR_ALIAS_POS]),
        .lm_alias_i(opt_q[bpoc_pkg::P_LM_ALIAS_POS]),
        .match_o(p_match_o)
    );

    // RL4 RL5 RL7 secondary retry alias
    bpoc_retry_match u_s_match (
        .retry_cmd_i(s_retry_cmd_i),
        .queued_cmd_i(s_queued_cmd_i),
        .rd_alias_i(opt_q[bpoc_pkg::S_RD_ALIAS_POS]),
        .wr_alias_i(opt_q[bpoc_pkg::S_WR_ALIAS_POS]),
        .lm_alias_i(opt_q[bpoc_pkg::S_LM_ALIAS_POS]),
        .match_o(s_match_o)
    );

    // RL8 primary write-invalidate forwarding
    always_comb
    begin
        s_fwd_cmd_o = p_accept_cmd_i;
        p_wi_disc_o = 1'b0;
        if (p_accept_cmd_i == bpoc_pkg::WRITE_AND_INVALIDATE_CMD)
        begin
            if (opt_q[bpoc_pkg::P_WI_DISC_POS])
            begin
                p_wi_disc_o = 1'b1;
            end
            else
            begin
                s_fwd_cmd_o = bpoc_pkg::PLAIN_MEMORY_WRITE_CMD;
            end
        end
    end

    // RL9 secondary write-invalidate forwarding
    always_comb
    begin
        p_fwd_cmd_o = s_accept_cmd_i;
        s_wi_disc_o = 1'b0;
        if (s_accept_cmd_i == bpoc_pkg::WRITE_AND_INVALIDATE_CMD)
        begin
            if (opt_q[bpoc_pkg::S_WI_DISC_POS])
            begin
                s_wi_disc_o = 1'b1;
            end
            else
            begin
                p_fwd_cmd_o = bpoc_pkg::PLAIN_MEMORY_WRITE_CMD;
            end
        end
    end

    // RL12 RL10 primary request hold
    bpoc_req_hold u_p_req (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .want_i(p_want_i),
        .hold_long_i(opt_q[bpoc_pkg::P_HOLD_POS]),
        .long_lock_i(opt_q[bpoc_pkg::LONG_LOCK_POS]),
        .lock_i(p_lock_i),
        .frame_n_i(p_frame_n_s),
        .pending_i(p_pending_i),
        .target_term_i(p_target_term_i),
        .req_n_o(p_req_n_o)
    );

    // RL11 RL10 secondary request hold
    bpoc_req_hold u_s_req (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .want_i(s_want_i),
        .hold_long_i(opt_q[bpoc_pkg::S_HOLD_POS]),
        .long_lock_i(opt_q[bpoc_pkg::LONG_LOCK_POS]),
        .lock_i(s_lock_i),
        .frame_n_i(s_frame_n_s),
        .pending_i(s_pending_i),
        .target_term_i(s_target_term_i),
        .req_n_o(s_req_n_o)
    );
endmodule
`default_nettype wire

//--- include/bpoc_pkg.sv
// Package for the bridge port option control block
package bpoc_pkg;
    // Register map, byte address of the option word
    localparam logic [7:0] OPT_ADDR = 8'h74;
    localparam logic [15:0] OPT_RESET = 16'h0C6A;
    localparam logic [15:0] OPT_WMASK = 16'h0FFE;
    // Field positions
    localparam int P_RD_ALIAS_POS = 1;
    localparam int P_WR_ALIAS_POS = 2;
    localparam int S_RD_ALIAS_POS = 3;
    localparam int S_WR_ALIAS_POS = 4;
    localparam int P_LM_ALIAS_POS = 5;
    localparam int S_LM_ALIAS_POS = 6;
    localparam int P_WI_DISC_POS = 7;
    localparam int S_WI_DISC_POS = 8;
    localparam int LONG_LOCK_POS = 9;
    localparam int S_HOLD_POS = 10;
    localparam int P_HOLD_POS = 11;
    // PCI bus commands
    localparam logic [3:0] PLAIN_MEMORY_READ_CMD = 4'h6;
    localparam logic [3:0] PLAIN_MEMORY_WRITE_CMD = 4'h7;
    localparam logic [3:0] MEMORY_READ_MULTIPLE_CMD = 4'hC;
    localparam logic [3:0] MEMORY_READ_LINE_CMD = 4'hE;
    localparam logic [3:0] WRITE_AND_INVALIDATE_CMD = 4'hF;
    typedef enum logic [2:0] {
        BPOC_REQ_IDLE = 3'b001,
        BPOC_REQ_WAIT = 3'b010,
        BPOC_REQ_HOLD = 3'b100
    } bpoc_req_state_t;
endpackage

//--- test/bpoc_checker.sv
// Assertion checker for the port option control block
`timescale 1ns/1ps
`default_nettype none
module bpoc_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic [3:0] p_retry_cmd_i,
    input wire logic [3:0] p_queued_cmd_i,
    input wire logic p_match_o,
    input wire logic [3:0] s_retry_cmd_i,
    input wire logic [3:0] s_queued_cmd_i,
    input wire logic s_match_o,
    input wire logic [3:0] p_accept_cmd_i,
    input wire logic [3:0] s_fwd_cmd_o,
    input wire logic p_wi_disc_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && ce_i;
    chk_ack_mapped: assert property
        (take && wb_adr_i == bpoc_pkg::OPT_ADDR |=> wb_ack_o && !wb_err_o)
        else $error("no ack");
    chk_err_unmapped: assert property
        (take && wb_adr_i != bpoc_pkg::OPT_ADDR |=> wb_err_o && !wb_ack_o)
        else $error("no err");
    chk_ack_pulse: assert property
        (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    chk_rsvd_zero: assert property
        (wb_ack_o |-> wb_dat_o[31:12] == 20'h0 && !wb_dat_o[0])
        else $error("reserved bits set");
    // Read data moves only on an accepted access
    chk_dat_hold: assert property
        (!take |=> $stable(wb_dat_o)) else $error("read data moved");
    chk_p_exact: assert property
        (p_retry_cmd_i == p_queued_cmd_i |-> p_match_o) else $error("p miss");
    chk_s_exact: assert property
        (s_retry_cmd_i == s_queued_cmd_i |-> s_match_o) else $error("s miss");
    chk_p_wi_fwd: assert property
        (p_accept_cmd_i == 4'hF && !p_wi_disc_o |-> s_fwd_cmd_o == 4'h7)
        else $error("bad forward");
endmodule
bind bpoc_top bpoc_checker u_chk (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
    .wb_stb_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .p_retry_cmd_i,
    .p_queued_cmd_i, .p_match_o, .s_retry_cmd_i, .s_queued_cmd_i,
    .s_match_o, .p_accept_cmd_i, .s_fwd_cmd_o, .p_wi_disc_o);
`default_nettype wire

//--- test/bpoc_far_model.sv
// Far-side arbiter and target model for one bridge port
`timescale 1ns/1ps
`default_nettype none
module bpoc_far_model #(parameter int GNT_DLY = 2) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_n_i,
    input wire logic stop_i,
    output logic frame_n_o = 1'b1,
    output logic term_o = 1'b0
);
    int cnt;
    logic done;
    // One frame per request, so a held request gets no second grant
    always @(posedge clk_i)
    begin
        term_o <= 1'b0;
        if (rst_i)
        begin
            cnt <= 0;
            done <= 1'b0;
            frame_n_o <= 1'b1;
        end
        else if (cnt != 0 || (!req_n_i && !done))
        begin
            cnt <= (cnt == GNT_DLY + 3) ? 0 : cnt + 1;
            frame_n_o <= !(cnt >= GNT_DLY && cnt < GNT_DLY + 3);
            if (cnt == GNT_DLY + 3)
            begin
                done <= 1'b1;
                term_o <= stop_i;
            end
        end
        else if (req_n_i)
            done <= 1'b0;
    end
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Testbench for the bridge port option control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [3:0] RD = bpoc_pkg::PLAIN_MEMORY_READ_CMD;
    localparam logic [3:0] WR = bpoc_pkg::PLAIN_MEMORY_WRITE_CMD;
    localparam logic [3:0] RM = bpoc_pkg::MEMORY_READ_MULTIPLE_CMD;
    localparam logic [3:0] RL = bpoc_pkg::MEMORY_READ_LINE_CMD;
    localparam logic [3:0] WI = bpoc_pkg::WRITE_AND_INVALIDATE_CMD;
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0, wb_we_i = 1'b0, er, wb_ack_o, wb_err_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h3;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
    logic [3:0] p_retry_cmd_i = 4'h0, p_queued_cmd_i = 4'h0, s_fwd_cmd_o;
    logic [3:0] s_retry_cmd_i = 4'h0, s_queued_cmd_i = 4'h0, p_fwd_cmd_o;
    logic [3:0] p_accept_cmd_i = 4'h0, s_accept_cmd_i = 4'h0;
    logic p_match_o, s_match_o, p_wi_disc_o, s_wi_disc_o, p_req_n_o;
    logic p_want_i = 1'b0, s_want_i = 1'b0, lock = 1'b0, pend = 1'b0;
    logic stop = 1'b0, p_frame_n_i, s_frame_n_i, s_req_n_o;
    logic p_target_term_i, s_target_term_i;
    int n_mismatch = 0, checks = 0;
    logic [3:0] cmd [5] = '{RD, WR, RM, RL, WI};
    logic [11:0] opts [9] = '{12'h000, 12'h002, 12'h004, 12'h008, 12'h010,
        12'h020, 12'h040, 12'h080, 12'h100};
    logic [11:0] ropt [4] = '{12'h000, 12'hC00, 12'h200, 12'hC00};
    bpoc_top u_dut (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
        .p_retry_cmd_i, .p_queued_cmd_i, .p_match_o, .s_retry_cmd_i,
        .s_queued_cmd_i, .s_match_o, .p_accept_cmd_i, .s_accept_cmd_i,
        .s_fwd_cmd_o, .p_fwd_cmd_o, .p_wi_disc_o, .s_wi_disc_o, .p_want_i,
        .p_lock_i(lock), .p_frame_n_i, .p_pending_i(pend), .p_target_term_i,
        .p_req_n_o, .s_want_i, .s_lock_i(lock), .s_frame_n_i,
        .s_pending_i(pend), .s_target_term_i, .s_req_n_o);
    bpoc_far_model #(.GNT_DLY(1)) u_pfar (.clk_i, .rst_i, .stop_i(stop),
        .req_n_i(p_req_n_o), .frame_n_o(p_frame_n_i), .term_o(p_target_term_i));
    bpoc_far_model #(.GNT_DLY(4)) u_sfar (.clk_i, .rst_i, .stop_i(stop),
        .req_n_i(s_req_n_o), .frame_n_o(s_frame_n_i), .term_o(s_target_term_i));
    initial
        forever #2.5 clk_i = ~clk_i;
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        conclude();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0, d};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        if (n == 20)
            n_mismatch++;
        rdat = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    function automatic logic em(logic [3:0] r, q, logic rd, wr, lm);
        return r == q || (rd && q == RD && (r == RL || r == RM))
            || (wr && q == WR && r == WI)
            || (lm && ((r == RL && q == RM) || (r == RM && q == RL)));
    endfunction
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h74, 16'h0);
        chk(rdat, 32'h0C6A);
        wb(1'b1, 8'h74, 16'hFFFF);
        wb(1'b1, 8'h70, 16'h0);
        chk(32'(er), 32'h1);
        wb(1'b0, 8'h74, 16'h0);
        chk(rdat, 32'h0FFE);
        // Low lane only: the upper option byte must survive
        wb_sel_i <= 4'h1;
        wb(1'b1, 8'h74, 16'h0000);
        wb_sel_i <= 4'h3;
        wb(1'b0, 8'h74, 16'h0);
        chk(rdat, 32'h0F00);
        $display("register test done");
        foreach (opts[i])
        begin
            wb(1'b1, 8'h74, {4'h0, opts[i]});
            foreach (cmd[r])
                foreach (cmd[q])
                begin
                    @(posedge clk_i);
                    p_retry_cmd_i <= cmd[r];
                    s_retry_cmd_i <= cmd[r];
                    p_queued_cmd_i <= cmd[q];
                    s_queued_cmd_i <= cmd[q];
                    p_accept_cmd_i <= cmd[r];
                    s_accept_cmd_i <= cmd[r];
                    @(negedge clk_i);
                    chk(32'(p_match_o), 32'(em(cmd[r], cmd[q], opts[i][1],
                        opts[i][2], opts[i][5])));
                    chk(32'(s_match_o), 32'(em(cmd[r], cmd[q], opts[i][3],
                        opts[i][4], opts[i][6])));
                    if (cmd[r] == WI)
                    begin
                        chk(32'(p_wi_disc_o), 32'(opts[i][7]));
                        chk(32'(s_wi_disc_o), 32'(opts[i][8]));
                        if (!opts[i][7])
                            chk(32'(s_fwd_cmd_o), 32'(WR));
                        if (!opts[i][8])
                            chk(32'(p_fwd_cmd_o), 32'(WR));
                    end
                    else
                    begin
                        // Other commands pass through untouched
                        chk(32'(p_wi_disc_o), 32'h0);
                        chk(32'(s_wi_disc_o), 32'h0);
                        chk(32'(s_fwd_cmd_o), 32'(cmd[r]));
                        chk(32'(p_fwd_cmd_o), 32'(cmd[r]));
                    end
                end
        end
        $display("match test done");
        for (int c = 0; c < 4; c++)
        begin
            wb(1'b1, 8'h74, {4'h0, ropt[c]});
            @(posedge clk_i);
            p_want_i <= 1'b1;
            s_want_i <= 1'b1;
            pend <= 1'b1;
            lock <= (c == 2);
            stop <= (c == 3);
            repeat (14)
            begin
                @(posedge clk_i);
                if (p_frame_n_i === 1'b0)
                    p_want_i <= 1'b0;
                if (s_frame_n_i === 1'b0)
                    s_want_i <= 1'b0;
            end
            // Hold mode is latched, so clearing it now must not release
            if (c == 1)
                wb(1'b1, 8'h74, 16'h0);
            repeat (6) @(posedge clk_i);
            @(negedge clk_i);
            chk(32'(p_req_n_o), 32'(c == 0 || c == 3));
            chk(32'(s_req_n_o), 32'(c == 0 || c == 3));
            @(posedge clk_i);
            pend <= 1'b0;
            repeat (4) @(posedge clk_i);
            @(negedge clk_i);
            chk(32'({p_req_n_o, s_req_n_o}), 32'h3);
        end
        $display("request test done");
        conclude();
    end
endmodule
`default_nettype wire
